// [src/timer_pwm_lowpower_irq.sv]
// 16-bit timer with pwm mode, captures, overflow and low-power behaviour
////////////////////////////////////////////////////////////////////////////
// Behaviour
// - pwm mode owns compare a and period compare
// - in pwm, shadows load only at period end
// - high byte write locks shadow transfer
// - pwm compares always enabled
// - edge match drives first level
// - period match drives second level
// - counter ticks per prescaled or external clock
// - period match reloads counter to FFFC
// - levels 1/0 give pulse b minus a
// - equal levels give constant pin
// - each interval is value plus five
// - no compare flags in pwm mode
// - period match sets capture a flag
// - capture a pin disconnected in pwm
// - pwm overrides single pulse mode
// - wait mode: timer runs, irq wakes
// - halt freezes counter, resumes after wake
// - capture edge in halt arms capture
// - five events, wait exit, none halt
// - one irq, enable and mask gated
// - three control regs, six data pairs
// - clock select 00/4 01/2 10/8 11/ext
// - pin enable only routes waveform
// - flag clears after status read, low access
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
module timer_pwm_lowpower_irq
    import timer_pwm_pkg::*;
(
    input  wire logic              sys_clk_in,
    input  wire logic              nrst_in,
    input  wire logic [ADDR_W-1:0] awaddr_in,
    input  wire logic              awvalid_in,
    output logic                   awready_out,
    input  wire logic [31:0]       wdata_in,
    input  wire logic [3:0]        wstrb_in,
    input  wire logic              wvalid_in,
    output logic                   wready_out,
    output logic [1:0]             bresp_out,
    output logic                   bvalid_out,
    input  wire logic              bready_in,
    input  wire logic [ADDR_W-1:0] araddr_in,
    input  wire logic              arvalid_in,
    output logic                   arready_out,
    output logic [31:0]            rdata_out,
    output logic [1:0]             rresp_out,
    output logic                   rvalid_out,
    input  wire logic              rready_in,
    input  wire logic              capture_a_pin_in,
    input  wire logic              capture_b_pin_in,
    input  wire logic              ext_clk_pin_in,
    input  wire logic              halt_mode_in,
    input  wire logic              wait_mode_in,
    input  wire logic              cpu_irq_mask_in,
    output logic                   waveform_out_pin_out,
    output logic                   waveform_pin_enable_out,
    output logic                   timer_irq_out,
    output logic                   wait_wake_out
);

    ////////////////////////////////////////////////////////////////////////
    // bus state
    logic        aw_rdy_r, aw_rdy_nxt;
    logic        w_rdy_r, w_rdy_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        ar_rdy_r, ar_rdy_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic        wr_fire, rd_fire, wr_ok, rd_ok;
    logic [7:0]  rd_byte;

    // timer state
    timer_control_one_t c1_r, c1_nxt;
    timer_control_two_t c2_r, c2_nxt;
    timer_flags_reg_t   fl_r, fl_nxt;
    timer_flags_reg_t   arm_r, arm_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [2:0]  presc_r, presc_nxt;
    logic [15:0] cmp_a_r, cmp_a_nxt;
    logic [15:0] cmp_b_r, cmp_b_nxt;
    logic [15:0] sh_a_r, sh_a_nxt;
    logic [15:0] sh_b_r, sh_b_nxt;
    logic        lock_a_r, lock_a_nxt;
    logic        lock_b_r, lock_b_nxt;
    logic [15:0] cap_a_r, cap_a_nxt;
    logic [15:0] cap_b_r, cap_b_nxt;
    logic        hold_a_r, hold_a_nxt;
    logic        hold_b_r, hold_b_nxt;
    logic        halt_d_r;
    logic        pin_r, pin_nxt;
    logic        pin_en_r, pin_en_nxt;
    logic        irq_r, irq_nxt;
    logic        wake_r, wake_nxt;

    // pin synchronisers: bit 0 capture a, 1 capture b, 2 external clock
    logic [2:0]  meta_r, sync_r, prev_r;
    logic [2:0]  pins, rise, fall;
    logic        edge_a, edge_b, ext_tick;
    logic        run, tick, pwm, pending;
    logic [2:0]  lim;

    assign pins = {ext_clk_pin_in, capture_b_pin_in, capture_a_pin_in};

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers, then one more flop for edge detection
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
            prev_r <= 3'h0;
        end else begin
            meta_r <= pins;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    generate
        for (genvar i = 0; i < 3; i++) begin : g_edge
            assign rise[i] = sync_r[i] & ~prev_r[i];
            assign fall[i] = ~sync_r[i] & prev_r[i];
        end
    endgenerate

    assign edge_a   = c1_r.edge_a_rising ? rise[0] : fall[0];
    assign edge_b   = c2_r.edge_b_rising ? rise[1] : fall[1];
    assign ext_tick = c2_r.ext_edge_rising ? rise[2] : fall[2];

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave: write ready is raised once both address and data wait
    assign wr_fire = aw_rdy_r & w_rdy_r;
    assign rd_fire = ar_rdy_r;

    always_comb begin
        wr_ok = 1'b1;
        unique case (awaddr_in)
            A_CTRL_ONE, A_CTRL_TWO, A_FLAGS, A_CAP_A_HI, A_CAP_A_LO,
            A_CMP_A_HI, A_CMP_A_LO, A_CMP_B_HI, A_CMP_B_LO, A_CNT_HI,
            A_CNT_LO, A_ACNT_HI, A_ACNT_LO, A_CAP_B_HI, A_CAP_B_LO: begin
                wr_ok = 1'b1;
            end
            default: begin
                wr_ok = 1'b0;
            end
        endcase
    end

    always_comb begin
        rd_ok   = 1'b1;
        rd_byte = 8'h00;
        unique case (araddr_in)
            A_CTRL_ONE: rd_byte = c1_r;
            A_CTRL_TWO: rd_byte = c2_r;
            A_FLAGS:    rd_byte = fl_r;
            A_CAP_A_HI: rd_byte = cap_a_r[15:8];
            A_CAP_A_LO: rd_byte = cap_a_r[7:0];
            A_CMP_A_HI: rd_byte = cmp_a_r[15:8];
            A_CMP_A_LO: rd_byte = cmp_a_r[7:0];
            A_CMP_B_HI: rd_byte = cmp_b_r[15:8];
            A_CMP_B_LO: rd_byte = cmp_b_r[7:0];
            A_CNT_HI,
            A_ACNT_HI:  rd_byte = cnt_r[15:8];
            A_CNT_LO,
            A_ACNT_LO:  rd_byte = cnt_r[7:0];
            A_CAP_B_HI: rd_byte = cap_b_r[15:8];
            A_CAP_B_LO: rd_byte = cap_b_r[7:0];
            default: begin
                rd_ok   = 1'b0;
                rd_byte = 8'h00;
            end
        endcase
    end

    always_comb begin
        aw_rdy_nxt = 1'b0;
        w_rdy_nxt  = 1'b0;
        bvalid_nxt = bvalid_r;
        bresp_nxt  = bresp_r;
        ar_rdy_nxt = 1'b0;
        rvalid_nxt = rvalid_r;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (awvalid_in && wvalid_in && !wr_fire && !bvalid_r) begin
            aw_rdy_nxt = 1'b1;
            w_rdy_nxt  = 1'b1;
        end
        if (wr_fire) begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_r && bready_in) begin
            bvalid_nxt = 1'b0;
        end
        if (arvalid_in && !rd_fire && !rvalid_r) begin
            ar_rdy_nxt = 1'b1;
        end
        if (rd_fire) begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = {24'h000000, rd_byte};
            rresp_nxt  = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && rready_in) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            aw_rdy_r <= 1'b0;
            w_rdy_r  <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
            ar_rdy_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h00000000;
            rresp_r  <= RESP_OKAY;
        end else begin
            aw_rdy_r <= aw_rdy_nxt;
            w_rdy_r  <= w_rdy_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r  <= bresp_nxt;
            ar_rdy_r <= ar_rdy_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r  <= rdata_nxt;
            rresp_r  <= rresp_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler and tick
    assign pwm = c2_r.pwm_mode;
    assign run = !halt_mode_in && !fl_r.timer_disable;

    always_comb begin
        unique case (c2_r.timer_clock_select)
            CLK_DIV2: lim = LIM_DIV2;
            CLK_DIV8: lim = LIM_DIV8;
            default:  lim = LIM_DIV4;
        endcase
    end

    assign tick = run && ((c2_r.timer_clock_select == CLK_EXT) ? ext_tick
                                                             : presc_r >= lim);

    ////////////////////////////////////////////////////////////////////////
    // timer next state
    always_comb begin
        logic acc_lo_wr;
        acc_lo_wr  = wr_fire && wr_ok && wstrb_in[0];
        c1_nxt     = c1_r;
        c2_nxt     = c2_r;
        fl_nxt     = fl_r;
        arm_nxt    = arm_r;
        cnt_nxt    = cnt_r;
        presc_nxt  = presc_r;
        cmp_a_nxt  = cmp_a_r;
        cmp_b_nxt  = cmp_b_r;
        sh_a_nxt   = sh_a_r;
        sh_b_nxt   = sh_b_r;
        lock_a_nxt = lock_a_r;
        lock_b_nxt = lock_b_r;
        cap_a_nxt  = cap_a_r;
        cap_b_nxt  = cap_b_r;
        hold_a_nxt = hold_a_r;
        hold_b_nxt = hold_b_r;
        pin_nxt    = pin_r;

        // software writes
        if (acc_lo_wr) begin
            unique case (awaddr_in)
                A_CTRL_ONE: c1_nxt = wdata_in[7:0];
                A_CTRL_TWO: c2_nxt = wdata_in[7:0];
                A_FLAGS:    fl_nxt.timer_disable = wdata_in[2];
                A_CMP_A_HI: begin
                    cmp_a_nxt[15:8] = wdata_in[7:0];
                    lock_a_nxt      = 1'b1;
                end
                A_CMP_A_LO: begin
                    cmp_a_nxt[7:0] = wdata_in[7:0];
                    lock_a_nxt     = 1'b0;
                end
                A_CMP_B_HI: begin
                    cmp_b_nxt[15:8] = wdata_in[7:0];
                    lock_b_nxt      = 1'b1;
                end
                A_CMP_B_LO: begin
                    cmp_b_nxt[7:0] = wdata_in[7:0];
                    lock_b_nxt     = 1'b0;
                end
                default: begin
                end
            endcase
        end

        // two-step flag clear; the status read arms, the low access clears
        if (rd_fire && araddr_in == A_FLAGS) begin
            arm_nxt.capture_a_flag    = fl_r.capture_a_flag;
            arm_nxt.edge_match_flag   = fl_r.edge_match_flag;
            arm_nxt.overflow_flag     = fl_r.overflow_flag;
            arm_nxt.capture_b_flag    = fl_r.capture_b_flag;
            arm_nxt.period_match_flag = fl_r.period_match_flag;
        end
        if ((rd_fire && araddr_in == A_CAP_A_LO) ||
            (acc_lo_wr && awaddr_in == A_CAP_A_LO)) begin
            fl_nxt.capture_a_flag  &= ~arm_r.capture_a_flag;
            arm_nxt.capture_a_flag  = 1'b0;
        end
        if ((rd_fire && araddr_in == A_CMP_A_LO) ||
            (acc_lo_wr && awaddr_in == A_CMP_A_LO)) begin
            fl_nxt.edge_match_flag  &= ~arm_r.edge_match_flag;
            arm_nxt.edge_match_flag  = 1'b0;
        end
        // the alternate counter view leaves the overflow flag alone
        if ((rd_fire && araddr_in == A_CNT_LO) ||
            (acc_lo_wr && awaddr_in == A_CNT_LO)) begin
            fl_nxt.overflow_flag  &= ~arm_r.overflow_flag;
            arm_nxt.overflow_flag  = 1'b0;
        end
        if ((rd_fire && araddr_in == A_CAP_B_LO) ||
            (acc_lo_wr && awaddr_in == A_CAP_B_LO)) begin
            fl_nxt.capture_b_flag  &= ~arm_r.capture_b_flag;
            arm_nxt.capture_b_flag  = 1'b0;
        end
        if ((rd_fire && araddr_in == A_CMP_B_LO) ||
            (acc_lo_wr && awaddr_in == A_CMP_B_LO)) begin
            fl_nxt.period_match_flag  &= ~arm_r.period_match_flag;
            arm_nxt.period_match_flag  = 1'b0;
        end
        fl_nxt.unused = 2'h0;

        // prescaler freezes with the counter
        if (run) begin
            presc_nxt = (tick || c2_r.timer_clock_select == CLK_EXT) ? 3'h0
                                                                     : presc_r + 3'h1;
        end

        // shadows track the registers outside pwm so entry starts clean
        if (!pwm) begin
            sh_a_nxt = cmp_a_r;
            sh_b_nxt = cmp_b_r;
            if (c1_r.force_a) begin
                pin_nxt = c1_r.level_after_edge_match;
            end
        end

        // hardware sets come last so they win over a clear
        if (tick) begin
            cnt_nxt = cnt_r + 16'h0001;
            if (cnt_r == CNT_TOP) begin
                fl_nxt.overflow_flag = 1'b1;
            end
            if (pwm) begin
                // no lock gates the comparison itself
                if (cnt_r == sh_b_r) begin
                    cnt_nxt = CNT_RELOAD;
                    pin_nxt = c1_r.level_after_period_match;
                    fl_nxt.capture_a_flag = 1'b1;
                    if (!lock_a_r) begin
                        sh_a_nxt = cmp_a_r;
                    end
                    if (!lock_b_r) begin
                        sh_b_nxt = cmp_b_r;
                    end
                end else if (cnt_r == sh_a_r) begin
                    pin_nxt = c1_r.level_after_edge_match;
                end
                // compare flags untouched here
            end else begin
                if (!lock_a_r && cnt_r == cmp_a_r) begin
                    fl_nxt.edge_match_flag = 1'b1;
                    pin_nxt                = c1_r.level_after_edge_match;
                end
                if (!lock_b_r && cnt_r == cmp_b_r) begin
                    fl_nxt.period_match_flag = 1'b1;
                end
            end
        end

        // captures; edges during halt only arm, taken when halt ends
        if (halt_mode_in) begin
            if (edge_a && !pwm) begin
                hold_a_nxt = 1'b1;
            end
            if (edge_b) begin
                hold_b_nxt = 1'b1;
            end
        end else begin
            if ((edge_a && !pwm) || (halt_d_r && hold_a_r)) begin
                cap_a_nxt             = cnt_r;
                fl_nxt.capture_a_flag = 1'b1;
            end
            if (edge_b || (halt_d_r && hold_b_r)) begin
                cap_b_nxt             = cnt_r;
                fl_nxt.capture_b_flag = 1'b1;
            end
            hold_a_nxt = 1'b0;
            hold_b_nxt = 1'b0;
        end
    end

    always_comb begin
        pending = (c1_r.capture_irq_enable &
                   (fl_r.capture_a_flag | fl_r.capture_b_flag)) |
                  (c1_r.compare_irq_enable &
                   (fl_r.edge_match_flag | fl_r.period_match_flag)) |
                  (c1_r.overflow_irq_enable & fl_r.overflow_flag);
        irq_nxt    = pending && !cpu_irq_mask_in;
        // halt wake-up is not offered by any timer event
        wake_nxt   = pending && wait_mode_in;
        pin_en_nxt = c2_r.waveform_pin_enable && !fl_r.timer_disable;
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            c1_r     <= '0;
            c2_r     <= '0;
            fl_r     <= '0;
            arm_r    <= '0;
            cnt_r    <= CNT_RELOAD;
            presc_r  <= 3'h0;
            cmp_a_r  <= CMP_RESET;
            cmp_b_r  <= CMP_RESET;
            sh_a_r   <= CMP_RESET;
            sh_b_r   <= CMP_RESET;
            lock_a_r <= 1'b0;
            lock_b_r <= 1'b0;
            cap_a_r  <= 16'h0000;
            cap_b_r  <= 16'h0000;
            hold_a_r <= 1'b0;
            hold_b_r <= 1'b0;
            halt_d_r <= 1'b0;
            pin_r    <= 1'b0;
            pin_en_r <= 1'b0;
            irq_r    <= 1'b0;
            wake_r   <= 1'b0;
        end else begin
            c1_r     <= c1_nxt;
            c2_r     <= c2_nxt;
            fl_r     <= fl_nxt;
            arm_r    <= arm_nxt;
            cnt_r    <= cnt_nxt;
            presc_r  <= presc_nxt;
            cmp_a_r  <= cmp_a_nxt;
            cmp_b_r  <= cmp_b_nxt;
            sh_a_r   <= sh_a_nxt;
            sh_b_r   <= sh_b_nxt;
            lock_a_r <= lock_a_nxt;
            lock_b_r <= lock_b_nxt;
            cap_a_r  <= cap_a_nxt;
            cap_b_r  <= cap_b_nxt;
            hold_a_r <= hold_a_nxt;
            hold_b_r <= hold_b_nxt;
            halt_d_r <= halt_mode_in;
            pin_r    <= pin_nxt;
            pin_en_r <= pin_en_nxt;
            irq_r    <= irq_nxt;
            wake_r   <= wake_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign awready_out             = aw_rdy_r;
    assign wready_out              = w_rdy_r;
    assign bvalid_out              = bvalid_r;
    assign bresp_out               = bresp_r;
    assign arready_out             = ar_rdy_r;
    assign rvalid_out              = rvalid_r;
    assign rdata_out               = rdata_r;
    assign rresp_out               = rresp_r;
    assign waveform_out_pin_out    = pin_r;
    assign waveform_pin_enable_out = pin_en_r;
    assign timer_irq_out           = irq_r;
    assign wait_wake_out           = wake_r;

endmodule

// [src/timer_pwm_pkg.sv]
// constants, register map and register layouts of the pwm timer
package timer_pwm_pkg;
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  A_CTRL_ONE    = 8'h00;
    localparam logic [7:0]  A_CTRL_TWO    = 8'h04;
    localparam logic [7:0]  A_FLAGS       = 8'h08;
    localparam logic [7:0]  A_CAP_A_HI    = 8'h0C;
    localparam logic [7:0]  A_CAP_A_LO    = 8'h10;
    localparam logic [7:0]  A_CMP_A_HI    = 8'h14;
    localparam logic [7:0]  A_CMP_A_LO    = 8'h18;
    localparam logic [7:0]  A_CMP_B_HI    = 8'h1C;
    localparam logic [7:0]  A_CMP_B_LO    = 8'h20;
    localparam logic [7:0]  A_CNT_HI      = 8'h24;
    localparam logic [7:0]  A_CNT_LO      = 8'h28;
    localparam logic [7:0]  A_ACNT_HI     = 8'h2C;
    localparam logic [7:0]  A_ACNT_LO     = 8'h30;
    localparam logic [7:0]  A_CAP_B_HI    = 8'h34;
    localparam logic [7:0]  A_CAP_B_LO    = 8'h38;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [15:0] CNT_RELOAD    = 16'hFFFC;
    localparam logic [15:0] CNT_TOP       = 16'hFFFF;
    localparam logic [15:0] CMP_RESET     = 16'h8000;
    localparam logic [1:0]  CLK_DIV4      = 2'h0;
    localparam logic [1:0]  CLK_DIV2      = 2'h1;
    localparam logic [1:0]  CLK_DIV8      = 2'h2;
    localparam logic [1:0]  CLK_EXT       = 2'h3;
    localparam logic [2:0]  LIM_DIV2      = 3'h1;
    localparam logic [2:0]  LIM_DIV4      = 3'h3;
    localparam logic [2:0]  LIM_DIV8      = 3'h7;

    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic force_b;
        logic force_a;
        logic level_after_period_match;
        logic edge_a_rising;
        logic level_after_edge_match;
    } timer_control_one_t;

    typedef struct packed {
        logic       waveform_pin_enable;
        logic       pin_b_enable;
        logic       single_pulse_mode_bit;
        logic       pwm_mode;
        logic [1:0] timer_clock_select;
        logic       edge_b_rising;
        logic       ext_edge_rising;
    } timer_control_two_t;

    typedef struct packed {
        logic       capture_a_flag;
        logic       edge_match_flag;
        logic       overflow_flag;
        logic       capture_b_flag;
        logic       period_match_flag;
        logic       timer_disable;
        logic [1:0] unused;
    } timer_flags_reg_t;
endpackage

// [tb/pwm_load_model.sv]
// external load on the waveform pin, timing its pulses
module pwm_load_model (
    input wire logic sys_clk_in,
    input wire logic pin_in,
    input wire logic en_in,
    output int       high_out,
    output int       period_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int   hc = 0, pc = 0;
    logic last = '0;
    // a pin left to gpio starts no new period, but high_out still updates on each fall
    always @(posedge sys_clk_in) begin
        if (en_in && pin_in && !last) begin
            period_out = pc;
            pc = 0;
            hc = 0;
        end
        if (!pin_in && last) high_out = hc;
        pc = pc + 1;
        hc = hc + (pin_in ? 1 : 0);
        last = pin_in;
    end
endmodule

// [tb/timer_pwm_chk.sv]
// port assertions for the pwm timer
module timer_pwm_chk
    import timer_pwm_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic awready_out,
    input wire logic wready_out,
    input wire logic bvalid_out,
    input wire logic bready_in,
    input wire logic arready_out,
    input wire logic rvalid_out,
    input wire logic rready_in,
    input wire logic cpu_irq_mask_in,
    input wire logic wait_mode_in,
    input wire logic halt_mode_in,
    input wire logic timer_irq_out,
    input wire logic wait_wake_out,
    input wire logic waveform_out_pin_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////
    sequence s_wr_take; awready_out && wready_out; endsequence
    property p_wr_pair; awready_out |-> wready_out; endproperty
    a_wr_pair: assert property (p_wr_pair) else $error("ready split");
    property p_wr_resp; s_wr_take |=> !awready_out && bvalid_out; endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("no bvalid");
    property p_b_hold; bvalid_out && !bready_in |=> bvalid_out; endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid lost");
    property p_rd_resp; arready_out |=> !arready_out && rvalid_out; endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("no rvalid");
    property p_r_hold; rvalid_out && !rready_in |=> rvalid_out; endproperty
    a_r_hold: assert property (p_r_hold) else $error("rvalid lost");
    property p_mask; cpu_irq_mask_in |=> !timer_irq_out; endproperty
    a_mask: assert property (p_mask) else $error("masked irq");
    property p_wake; !wait_mode_in |=> !wait_wake_out; endproperty
    a_wake: assert property (p_wake) else $error("wake outside wait");
    // three samples so a tick already in flight may land first
    property p_halt; halt_mode_in [*3] |-> $stable(waveform_out_pin_out); endproperty
    a_halt: assert property (p_halt) else $error("pin moved in halt");
endmodule
bind timer_pwm_lowpower_irq timer_pwm_chk chk (.*);

// [tb/timer_pwm_lowpower_irq_bench.sv]
// self-checking bench for the pwm timer
module timer_pwm_lowpower_irq_bench
    import timer_pwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = '0, nrst_in = '0, awvalid_in = '0, wvalid_in = '0, bready_in = '0;
    logic arvalid_in = '0, rready_in = '0, capture_a_pin_in = '0, capture_b_pin_in = '0;
    logic ext_clk_pin_in = '0, halt_mode_in = '0, wait_mode_in = '0, cpu_irq_mask_in = '0;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out, timer_irq_out;
    logic waveform_out_pin_out, waveform_pin_enable_out, wait_wake_out;
    logic [ADDR_W-1:0] awaddr_in = '0, araddr_in = '0;
    logic [31:0] wdata_in = '0, rdata_out;
    logic [3:0] wstrb_in = 4'hF;
    logic [1:0] bresp_out, rresp_out, rs;
    logic [7:0] rd, bv, cnt;
    int num_errors = 0, cmp_count = 0, p_high, p_len, acc;
    integer seed = 7;
    always #12.5 sys_clk_in = ~sys_clk_in;
    timer_pwm_lowpower_irq uut (.*);
    pwm_load_model load (.sys_clk_in, .pin_in(waveform_out_pin_out),
        .en_in(waveform_pin_enable_out), .high_out(p_high), .period_out(p_len));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s %h/%h", $time, m, got, exp);
        end
    endtask
    task automatic wt(ref logic s, input logic v);
        int i;
        for (i = 0; i < 90000 && s !== v; i++) @(posedge sys_clk_in);
        if (i == 90000) begin
            num_errors++;
            $display("mismatch at %0t: wait expired", $time);
            summarize();
        end
    endtask
    task automatic axw(input logic [7:0] a, d, input logic [1:0] er);
        {awaddr_in, wdata_in, awvalid_in, wvalid_in} <= {a, 24'h000000, d, 2'h3};
        wt(awready_out, 1'h1);
        {awvalid_in, wvalid_in} <= 2'h0;
        wt(bvalid_out, 1'h1);
        bready_in <= 1'h1;
        @(posedge sys_clk_in);
        bready_in <= 1'h0;
        chk(bresp_out, er, "bresp");
    endtask
    task automatic axr(input logic [7:0] a);
        {araddr_in, arvalid_in} <= {a, 1'h1};
        wt(arready_out, 1'h1);
        arvalid_in <= 1'h0;
        wt(rvalid_out, 1'h1);
        rready_in <= 1'h1;
        @(posedge sys_clk_in);
        rready_in <= 1'h0;
        {rd, rs} = {rdata_out[7:0], rresp_out};
    endtask
    task automatic periods(input int k);
        for (int i = 0; i < 2 * k; i++) wt(waveform_out_pin_out, i[0]);
        @(posedge sys_clk_in);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge sys_clk_in);
        nrst_in <= 1'h1;
        @(posedge sys_clk_in);
        axr(A_CMP_B_HI);
        chk(rd, 8'h80, "cmp reset");
        axr(8'h3C);
        chk(rs, RESP_SLVERR, "unmapped");
        axw(A_CTRL_ONE, 8'h81, RESP_OKAY);
        axw(A_CMP_A_HI, 8'h00, RESP_OKAY);
        axw(A_CMP_A_LO, 8'h08, RESP_OKAY);
        axw(A_CMP_B_HI, 8'h00, RESP_OKAY);
        axw(A_CMP_B_LO, 8'h14, RESP_OKAY);
        axw(A_CTRL_TWO, 8'hB6, RESP_OKAY);
        // shadows follow the compare registers until pwm starts
        periods(3);
        chk(waveform_pin_enable_out, 1'h1, "pin owner");
        chk(p_high, 24, "pulse");
        chk(p_len, 50, "period");
        axr(A_FLAGS);
        chk(rd & 8'h48, 8'h00, "cmp flags");
        chk(rd[7], 1'h1, "period flag");
        chk(timer_irq_out, 1'h1, "irq");
        {cpu_irq_mask_in, wait_mode_in} <= 2'h3;
        repeat (3) @(posedge sys_clk_in);
        chk(timer_irq_out, 1'h0, "masked");
        chk(wait_wake_out, 1'h1, "wake");
        {cpu_irq_mask_in, wait_mode_in} <= 2'h0;
        $display("test pwm basics done");
        axw(A_CMP_B_HI, 8'h01, RESP_OKAY);
        periods(3);
        chk(p_len, 50, "locked");
        bv = 8'h18 + 8'($random(seed) & 7);
        axw(A_CMP_B_HI, 8'h00, RESP_OKAY);
        axw(A_CMP_B_LO, bv, RESP_OKAY);
        periods(3);
        chk(p_len, 2 * (bv + 5), "new period");
        chk(p_high, 2 * (bv - 8), "new pulse");
        axw(A_CTRL_TWO, 8'hBA, RESP_OKAY);
        periods(3);
        chk(p_len, 8 * (bv + 5), "div8");
        $display("test double buffer done");
        axw(A_CTRL_ONE, 8'h80, RESP_OKAY);
        repeat (300) @(posedge sys_clk_in);
        acc = 0;
        repeat (100) @(posedge sys_clk_in) acc += (waveform_out_pin_out !== 1'h0);
        chk(acc, 0, "steady pin");
        halt_mode_in <= 1'h1;
        repeat (4) @(posedge sys_clk_in);
        axr(A_CNT_LO);
        cnt = rd;
        {capture_a_pin_in, capture_b_pin_in} <= 2'h3;
        repeat (20) @(posedge sys_clk_in);
        axr(A_CNT_LO);
        chk(rd, cnt, "frozen");
        {halt_mode_in, capture_a_pin_in} <= 2'h0;
        repeat (4) @(posedge sys_clk_in);
        axr(A_FLAGS);
        chk(rd[4], 1'h1, "capture b");
        axr(A_CAP_A_LO);
        chk(rd, 8'h00, "cap a");
        axr(A_CAP_B_LO);
        chk(rd, cnt, "cap at exit");
        axr(A_FLAGS);
        chk(rd[4], 1'h0, "flag clear");
        $display("test halt done");
        summarize();
    end
endmodule
